/* File: rsel_pkg.sv */
// constants and types shared by the reference input selector
package rsel_pkg;

    // ****************************************
    // register indices and byte addresses
    // ****************************************
    localparam int RSEL_NUM_IN = 2;
    localparam logic [7:0] RSEL_IDX_RANK = 8'h14;
    localparam logic [7:0] RSEL_IDX_CTRL = 8'h15;
    localparam logic [7:0] RSEL_IDX_HCNT = 8'h16;
    localparam logic [7:0] RSEL_IDX_HCFG = 8'h17;
    localparam logic [7:0] RSEL_IDX_STAT = 8'h18;
    localparam logic [7:0] RSEL_ADDR_RANK = 8'h50;
    localparam logic [7:0] RSEL_ADDR_CTRL = 8'h54;
    localparam logic [7:0] RSEL_ADDR_HCNT = 8'h58;
    localparam logic [7:0] RSEL_ADDR_HCFG = 8'h5C;
    localparam logic [7:0] RSEL_ADDR_STAT = 8'h60;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RSEL_RST_RANK = 8'hE0;
    localparam logic [7:0] RSEL_RST_CTRL = 8'h00;
    localparam logic [7:0] RSEL_RST_HCNT = 8'h80;
    localparam logic [7:0] RSEL_RST_HCFG = 8'h80;

    // ****************************************
    // field positions
    // ****************************************
    localparam int RSEL_CTRL_CHOICE_LSB = 0;
    localparam int RSEL_CTRL_MODE_LSB = 2;
    localparam int RSEL_CTRL_REVERT = 4;
    localparam int RSEL_CTRL_PREDIV = 5;
    localparam int RSEL_CTRL_LOSSMASK = 6;
    localparam logic [7:0] RSEL_CTRL_WMASK = 8'h7F;
    localparam int RSEL_HCFG_VCNT_LSB = 0;
    localparam int RSEL_HCFG_RATE_LSB = 6;
    localparam logic [7:0] RSEL_HCFG_WMASK = 8'hCF;
    localparam int RSEL_RATE_BASE_SHIFT = 15;

    // ****************************************
    // modes, ranks, responses
    // ****************************************
    localparam logic [1:0] RSEL_MODE_MANUAL = 2'h0;
    localparam logic [1:0] RSEL_MODE_AUTO = 2'h1;
    localparam logic [1:0] RSEL_MODE_SHORT = 2'h2;
    localparam logic [1:0] RSEL_MODE_AUTO_HOLD = 2'h3;
    localparam logic [1:0] RSEL_RANK_LOWEST = 2'h0;
    localparam logic [1:0] RSEL_RANK_HIGHEST = 2'h3;
    localparam logic [1:0] RSEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSEL_RESP_SLVERR = 2'h2;

    typedef enum logic {RSEL_ST_LOCKED, RSEL_ST_HOLDOFF} rsel_state_t;

endpackage : rsel_pkg

/* File: rsel_holdoff.sv */
// hold-off countdown timer driven by divided oscillator ticks
`timescale 1ns/100ps
module rsel_holdoff
    import rsel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_vcxo_tick,
    input wire logic [1:0] i_rate,
    input wire logic [7:0] i_reload,
    input wire logic i_run,
    output logic o_expire
);

    typedef struct packed {
        logic [17:0] pre;
        logic [7:0] cnt;
        logic expire;
    } rsel_hold_t;

    rsel_hold_t s_reg;
    rsel_hold_t s_next;
    logic [17:0] pre_limit;

    // ****************************************
    // countdown
    // ****************************************
    // prescale spans 2^15..2^18 ticks, so shorten i_vcxo_tick rate in sims
    always_comb
    begin
        s_next = s_reg;
        s_next.expire = 1'b0;
        pre_limit = 18'((18'h1 << (RSEL_RATE_BASE_SHIFT + int'(i_rate))) - 1);
        if (!i_run)
        begin
            s_next.pre = '0;
            s_next.cnt = i_reload;
        end
        else if (i_vcxo_tick)
        begin
            if (s_reg.pre >= pre_limit)
            begin
                s_next.pre = '0;
                // zero transition switches and reloads
                if (s_reg.cnt <= 8'h01)
                begin
                    s_next.expire = 1'b1;
                    s_next.cnt = i_reload;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt - 8'h01;
                end
            end
            else
            begin
                s_next.pre = s_reg.pre + 18'h00001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s_reg <= '{pre: '0, cnt: RSEL_RST_HCNT, expire: 1'b0};
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end

    assign o_expire = s_reg.expire;

endmodule : rsel_holdoff

/* File: rsel_top.sv */
// reference input selector with axi4-lite register slave
// Functional notes
// - two-bit rank per input, 00 lowest up to 11 highest
// - equal ranks resolve toward the lowest-numbered input
// - one-bit validation prediv: 0 divide by 1, 1 divide by 4
// - revert off: recovery of an unselected input changes nothing
// - revert on: recovery of an unselected input re-evaluates choice
// - revert switches only if recovered input outranks current one
// - revert has no effect in any manual mode (mode low bit 0)
// - modes 00 and 10 use the manual choice field only
// - automatic modes choose from loss states and ranks
// - mode 00 manual, 01 auto, 10 short holdover, 11 auto hold
// - revert bit is 0 after reset
// - manual choice 00 input 0, 01 input 1; ignored in auto modes
// - auto-hold mode counts down after loss, switches at zero, reloads
`timescale 1ns/100ps
module rsel_top
    import rsel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [1:0] i_ref_los,
    input wire logic i_vcxo_tick,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_ref_sel,
    output logic o_valid_counter_prediv,
    output logic [1:0] o_validation_count_setting,
    output logic o_ref_loss_mask
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] input_rank_levels;
        logic [7:0] ref_choice_control;
        logic [7:0] holdoff_count_value;
        logic [7:0] holdoff_valid_config;
        rsel_state_t state;
        logic sel;
        logic [1:0] los_prev;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsel_regs_t;

    rsel_regs_t s_reg;
    rsel_regs_t s_next;
    logic hold_expire;
    logic hold_run;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [1:0] rank_of(input logic [7:0] ranks,
                                           input int idx);
        // input 0 sits in the top bits
        rank_of = ranks[7 - 2 * idx -: 2];
    endfunction : rank_of

    function automatic logic best_valid(input logic [7:0] ranks,
                                        input logic [1:0] valid,
                                        input logic fallback);
        logic [1:0] best_rank;
        logic found;
        best_valid = fallback;
        best_rank = RSEL_RANK_LOWEST;
        found = 1'b0;
        for (int i = 0; i < RSEL_NUM_IN; i++)
        begin
            // strict compare keeps the lower index on a tie
            if (valid[i] && (!found || rank_of(ranks, i) > best_rank))
            begin
                found = 1'b1;
                best_rank = rank_of(ranks, i);
                best_valid = 1'(i);
            end
        end
    endfunction : best_valid

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == RSEL_ADDR_RANK) || (addr == RSEL_ADDR_CTRL) ||
                 (addr == RSEL_ADDR_HCNT) || (addr == RSEL_ADDR_HCFG) ||
                 (addr == RSEL_ADDR_STAT);
    endfunction : mapped

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [1:0] mode;
        logic [1:0] valid;
        logic [1:0] recov;
        logic revert;
        logic best;
        logic [7:0] rd;
        mode = s_reg.ref_choice_control[RSEL_CTRL_MODE_LSB +: 2];
        valid = ~i_ref_los;
        revert = s_reg.ref_choice_control[RSEL_CTRL_REVERT];
        recov = s_reg.los_prev & valid;
        recov[s_reg.sel] = 1'b0;
        best = best_valid(s_reg.input_rank_levels, valid, s_reg.sel);
        rd = 8'h00;
        s_next = s_reg;
        s_next.los_prev = i_ref_los;

        // selection
        if (!mode[0])
        begin
            // manual and short holdover modes follow the choice field
            // only the low bit names an input, as two inputs exist
            s_next.sel = s_reg.ref_choice_control[RSEL_CTRL_CHOICE_LSB];
            s_next.state = RSEL_ST_LOCKED;
        end
        else
        begin
            unique case (s_reg.state)
                RSEL_ST_LOCKED:
                begin
                    if (i_ref_los[s_reg.sel])
                    begin
                        if (mode == RSEL_MODE_AUTO)
                        begin
                            s_next.sel = best;
                        end
                        else
                        begin
                            s_next.state = RSEL_ST_HOLDOFF;
                        end
                    end
                    else if (revert)
                    begin
                        // only reached in auto modes
                        for (int i = 0; i < RSEL_NUM_IN; i++)
                        begin
                            if (recov[i] && rank_of(s_reg.input_rank_levels, i)
                                > rank_of(s_reg.input_rank_levels,
                                          int'(s_reg.sel)))
                            begin
                                s_next.sel = 1'(i);
                            end
                        end
                    end
                    // with revert clear a recovery is simply ignored
                end
                RSEL_ST_HOLDOFF:
                begin
                    if (!i_ref_los[s_reg.sel])
                    begin
                        s_next.state = RSEL_ST_LOCKED;
                    end
                    else if (hold_expire || mode == RSEL_MODE_AUTO)
                    begin
                        // stays here if nothing valid; counter retries
                        // plain auto mode never waits on the timer
                        s_next.sel = best;
                    end
                end
            endcase
        end

        // write channel
        if (i_awvalid && s_reg.awready)
        begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = i_awaddr;
        end
        if (i_wvalid && s_reg.wready)
        begin
            s_next.w_got = 1'b1;
            s_next.wdata = i_wdata[7:0];
            s_next.wstrb0 = i_wstrb[0];
        end
        if (s_reg.bvalid && i_bready)
        begin
            s_next.bvalid = 1'b0;
        end
        if (s_next.aw_got && s_next.w_got && !s_next.bvalid)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = mapped(s_next.awaddr) ? RSEL_RESP_OKAY
                                                 : RSEL_RESP_SLVERR;
            // status is read-only; narrow registers live in byte lane 0
            if (s_next.wstrb0)
            begin
                unique case (s_next.awaddr)
                    RSEL_ADDR_RANK: s_next.input_rank_levels = s_next.wdata;
                    RSEL_ADDR_CTRL: s_next.ref_choice_control =
                        s_next.wdata & RSEL_CTRL_WMASK;
                    RSEL_ADDR_HCNT: s_next.holdoff_count_value = s_next.wdata;
                    RSEL_ADDR_HCFG: s_next.holdoff_valid_config =
                        s_next.wdata & RSEL_HCFG_WMASK;
                    default: s_next.bresp = s_next.bresp;
                endcase
            end
        end

        // read channel
        if (s_reg.rvalid && i_rready)
        begin
            s_next.rvalid = 1'b0;
        end
        if (i_arvalid && s_reg.arready)
        begin
            unique case (i_araddr)
                RSEL_ADDR_RANK: rd = s_reg.input_rank_levels;
                RSEL_ADDR_CTRL: rd = s_reg.ref_choice_control;
                RSEL_ADDR_HCNT: rd = s_reg.holdoff_count_value;
                RSEL_ADDR_HCFG: rd = s_reg.holdoff_valid_config;
                RSEL_ADDR_STAT: rd = {4'h0, s_reg.state == RSEL_ST_HOLDOFF,
                                      valid, s_reg.sel};
                default: rd = 8'h00;
            endcase
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000, rd};
            s_next.rresp = mapped(i_araddr) ? RSEL_RESP_OKAY
                                            : RSEL_RESP_SLVERR;
        end

        // one of each kind in flight
        s_next.awready = !s_next.aw_got;
        s_next.wready = !s_next.w_got;
        s_next.arready = !s_next.rvalid;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s_reg <= '0;
            s_reg.input_rank_levels <= RSEL_RST_RANK;
            s_reg.ref_choice_control <= RSEL_RST_CTRL;
            s_reg.holdoff_count_value <= RSEL_RST_HCNT;
            s_reg.holdoff_valid_config <= RSEL_RST_HCFG;
            s_reg.state <= RSEL_ST_LOCKED;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
        end
        else if (i_ce)
        begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // hold-off timer
    // ****************************************
    assign hold_run = (s_reg.state == RSEL_ST_HOLDOFF);

    rsel_holdoff u_holdoff (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_vcxo_tick(i_vcxo_tick),
        .i_rate(s_reg.holdoff_valid_config[RSEL_HCFG_RATE_LSB +: 2]),
        .i_reload(s_reg.holdoff_count_value),
        .i_run(hold_run),
        .o_expire(hold_expire)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign o_awready = s_reg.awready;
    assign o_wready = s_reg.wready;
    assign o_bvalid = s_reg.bvalid;
    assign o_bresp = s_reg.bresp;
    assign o_arready = s_reg.arready;
    assign o_rvalid = s_reg.rvalid;
    assign o_rdata = s_reg.rdata;
    assign o_rresp = s_reg.rresp;
    assign o_ref_sel = s_reg.sel;
    // prediv only steers the external validation counter
    assign o_valid_counter_prediv =
        s_reg.ref_choice_control[RSEL_CTRL_PREDIV];
    assign o_validation_count_setting =
        s_reg.holdoff_valid_config[RSEL_HCFG_VCNT_LSB +: 2];
    assign o_ref_loss_mask = s_reg.ref_choice_control[RSEL_CTRL_LOSSMASK];

endmodule : rsel_top

/* File: rsel_checker.sv */
// concurrent checks on the reference selector ports
`timescale 1ns/100ps
module rsel_checker
    import rsel_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [1:0] i_ref_los,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic o_ref_sel,
    input wire logic o_valid_counter_prediv,
    input wire logic o_ref_loss_mask
);
    // ****************
    // control shadow
    // ****************
    // assumes address and data arrive together, as the bench sends them
    logic [7:0] ctrl_reg;
    logic lost_sel;
    logic wr_go;
    assign lost_sel = i_ref_los[o_ref_sel];
    assign wr_go = i_ce && i_awvalid && o_awready && i_wvalid && o_wready;
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ctrl_reg <= RSEL_RST_CTRL;
        else if (wr_go && i_wstrb[0] && i_awaddr == RSEL_ADDR_CTRL)
            ctrl_reg <= i_wdata[7:0] & RSEL_CTRL_WMASK;
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // ****************
    // assertions
    // ****************
    wr_answer_a: assert property (wr_go && !o_bvalid |=> o_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (i_ce && i_arvalid && o_arready
        |=> o_rvalid && o_rdata[31:8] == 24'h0)
        else $error("read response late or wide");
    rd_hold_a: assert property (o_rvalid && !i_rready
        |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken while busy");
    manual_sel_a: assert property (
        !ctrl_reg[RSEL_CTRL_MODE_LSB] && $stable(ctrl_reg)
        |-> o_ref_sel == ctrl_reg[RSEL_CTRL_CHOICE_LSB])
        else $error("manual choice not followed");
    cfg_out_a: assert property ($stable(ctrl_reg) |->
        o_valid_counter_prediv == ctrl_reg[RSEL_CTRL_PREDIV]
        && o_ref_loss_mask == ctrl_reg[RSEL_CTRL_LOSSMASK])
        else $error("config outputs wrong");
    auto_move_a: assert property (
        ctrl_reg[3:2] == RSEL_MODE_AUTO && $stable(ctrl_reg) && i_ce
        && lost_sel && !i_ref_los[!o_ref_sel]
        |=> o_ref_sel != $past(o_ref_sel))
        else $error("no move off lost input");
    keep_sel_a: assert property (
        ctrl_reg[3:2] == RSEL_MODE_AUTO && !ctrl_reg[RSEL_CTRL_REVERT]
        && $stable(ctrl_reg) && !lost_sel |=> $stable(o_ref_sel))
        else $error("selection changed without cause");
    hold_wait_a: assert property (
        ctrl_reg[3:2] == RSEL_MODE_AUTO_HOLD && $stable(ctrl_reg)
        && $rose(lost_sel) && $stable(o_ref_sel)
        |=> $stable(o_ref_sel) [*8])
        else $error("switched before hold-off");
endmodule : rsel_checker

/* File: rsel_ref_src.sv */
// model of the two monitored reference inputs and oscillator ticks
`timescale 1ns/100ps
module rsel_ref_src
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_fail,
    input wire logic i_run,
    output logic [1:0] o_ref_los,
    output logic o_vcxo_tick
);
    // monitor reports a loss one cycle after the input fails
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_ref_los <= 2'h0;
            o_vcxo_tick <= 1'b0;
        end
        else
        begin
            o_ref_los <= i_fail;
            o_vcxo_tick <= i_run;
        end
    end
endmodule : rsel_ref_src

/* File: rsel_top_tb.sv */
// self-checking bench for the reference input selector
`timescale 1ns/100ps
module rsel_top_tb import rsel_pkg::*;;
    logic i_clk, i_resetn, i_ce, i_vcxo_tick, run_req;
    logic [1:0] i_ref_los, fail_req, o_bresp, o_rresp;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic i_arvalid, o_arready, o_rvalid, i_rready, o_ref_sel;
    logic o_valid_counter_prediv, o_ref_loss_mask;
    logic [1:0] o_validation_count_setting;
    int n_fail, samples_checked;
    rsel_ref_src src_u (.i_clk, .i_resetn, .i_fail(fail_req),
        .i_run(run_req), .o_ref_los(i_ref_los), .o_vcxo_tick(i_vcxo_tick));
    rsel_top dut_u (.i_clk, .i_resetn, .i_ce, .i_ref_los, .i_vcxo_tick,
        .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
        .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_ref_sel,
        .o_valid_counter_prediv, .o_validation_count_setting,
        .o_ref_loss_mask);
    // ****************
    // bus and compare tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge i_clk);
            aw = aw | o_awready;
            w = w | o_wready;
            if (aw)
                i_awvalid <= 1'b0;
            if (w)
                i_wvalid <= 1'b0;
        end
        do @(posedge i_clk); while (o_bvalid !== 1'b1);
        // bready stays high: lowering it here would clash with the next call
        chk({30'h0, o_bresp}, {30'h0, er});
    endtask : wr
    // slow master: rready rises only after rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(posedge i_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_clk); while (o_rvalid !== 1'b1);
        i_rready <= 1'b1;
        do @(posedge i_clk); while (o_rvalid !== 1'b1);
        chk(o_rdata, {24'h0, ed});
        chk({30'h0, o_rresp}, {30'h0, er});
        i_rready <= 1'b0;
    endtask : rd
    task automatic sel_is(input logic e, input int n);
        while (o_ref_sel !== e && n > 0)
        begin
            @(posedge i_clk);
            n--;
        end
        chk({31'h0, o_ref_sel}, {31'h0, e});
    endtask : sel_is
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // ****************
    // clock, watchdog, tests
    // ****************
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (60000) @(posedge i_clk);
        n_fail++;
        finish_test();
    end
    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        {i_resetn, fail_req, run_req, i_awaddr, i_araddr, i_wdata} = '0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        i_ce = 1'b1;
        i_wstrb = 4'hF;
        step(16);
        i_resetn <= 1'b1;
        step(1);
        rd(RSEL_ADDR_CTRL, RSEL_RST_CTRL, RSEL_RESP_OKAY);
        rd(RSEL_ADDR_RANK, 8'hE0, RSEL_RESP_OKAY);
        rd(RSEL_ADDR_HCNT, 8'h80, RSEL_RESP_OKAY);
        rd(8'h7C, 8'h00, RSEL_RESP_SLVERR);
        wr(8'h7C, 8'h11, RSEL_RESP_SLVERR);
        $display("reset values test done");
        wr(RSEL_ADDR_CTRL, 8'h01, RSEL_RESP_OKAY);
        sel_is(1'b1, 2);
        fail_req <= 2'b10;
        step(4);
        sel_is(1'b1, 0);
        wr(RSEL_ADDR_CTRL, 8'h78, RSEL_RESP_OKAY);
        fail_req <= 2'b01;
        step(4);
        fail_req <= 2'b00;
        step(4);
        sel_is(1'b0, 0);
        chk({31'h0, o_valid_counter_prediv}, 32'h1);
        wr(RSEL_ADDR_HCFG, 8'h03, RSEL_RESP_OKAY);
        step(2);
        chk({30'h0, o_validation_count_setting}, 32'h3);
        $display("manual mode test done");
        wr(RSEL_ADDR_CTRL, 8'h05, RSEL_RESP_OKAY);
        fail_req <= 2'b01;
        sel_is(1'b1, 4);
        fail_req <= 2'b00;
        step(4);
        sel_is(1'b1, 0);
        wr(RSEL_ADDR_CTRL, 8'h14, RSEL_RESP_OKAY);
        fail_req <= 2'b01;
        step(4);
        fail_req <= 2'b00;
        sel_is(1'b0, 4);
        wr(RSEL_ADDR_RANK, 8'h00, RSEL_RESP_OKAY);
        fail_req <= 2'b01;
        sel_is(1'b1, 4);
        fail_req <= 2'b00;
        step(4);
        sel_is(1'b1, 0);
        $display("automatic mode test done");
        wr(RSEL_ADDR_RANK, 8'hE0, RSEL_RESP_OKAY);
        wr(RSEL_ADDR_HCNT, 8'h01, RSEL_RESP_OKAY);
        wr(RSEL_ADDR_HCFG, 8'h00, RSEL_RESP_OKAY);
        wr(RSEL_ADDR_CTRL, 8'h0C, RSEL_RESP_OKAY);
        run_req <= 1'b1;
        fail_req <= 2'b10;
        step(16);
        sel_is(1'b1, 0);
        rd(RSEL_ADDR_STAT, 8'h0B, RSEL_RESP_OKAY);
        sel_is(1'b0, 40000);
        $display("hold-off test done");
        finish_test();
    end
endmodule : rsel_top_tb
bind rsel_top rsel_checker chk_u (.i_clk, .i_resetn, .i_ce, .i_ref_los,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
    .i_rready, .o_ref_sel, .o_valid_counter_prediv, .o_ref_loss_mask);
